// [design/axis_channel.sv]
// One axis: settings, sensor sync, speed generator and pulse encoder
`timescale 1ns/10ps
module axis_channel
    import axis_cfg_pkg::*;
(
    input  wire logic              clock_i,           // Module clock
    input  wire logic              rst_n_i,           // Async reset
    input  wire logic              soft_rst_i,        // Software reset pulse
    input  wire logic              sel_i,             // Axis selected by mask
    input  wire logic              wr_pmode_i,        // Write pulse mode
    input  wire logic              wr_maxv_i,         // Write max speed
    input  wire logic              wr_lmt_i,          // Write limit levels
    input  wire logic              wr_stop_i,         // Write stop mode
    input  wire logic              wr_nh_i,           // Write near-origin level
    input  wire logic [2:0]        pmode_i,           // Pulse mode value
    input  wire logic [MAXV_W-1:0] maxv_i,            // Max speed value
    input  wire logic              fwd_lvl_i,         // Forward limit level
    input  wire logic              rev_lvl_i,         // Reverse limit level
    input  wire logic              stop_mode_i,       // Stop mode value
    input  wire logic              nh_lvl_i,          // Near-origin level
    input  wire logic              scale_ext_i,       // Use external scale
    input  wire logic [MAXV_W-1:0] scale_maxv_i,      // External max speed
    input  wire logic              run_i,             // Drive request level
    input  wire logic              dir_rev_i,         // 1 = reverse
    input  wire logic [SPEED_W-1:0] start_sp_i,       // Start speed, scaled units
    input  wire logic [SPEED_W-1:0] target_sp_i,      // Target speed, scaled units
    input  wire logic [SPEED_W-1:0] accel_i,          // Speed step per tick
    input  wire logic              fwd_lmt_i,         // Forward limit pin
    input  wire logic              rev_lmt_i,         // Reverse limit pin
    input  wire logic              near_origin_sensor_i, // Near-origin pin
    output logic                   pulse_out_plus_o,  // Plus output
    output logic                   pulse_out_minus_o, // Minus output
    output logic                   busy_o,            // Axis is driving
    output logic                   fwd_hit_o,         // Forward limit asserted
    output logic                   rev_hit_o,         // Reverse limit asserted
    output logic                   near_hit_o,        // Near-origin asserted
    output logic [MAXV_W-1:0]      maxv_o             // Stored max speed
);
    // ****************************************
    // Settings
    // ****************************************
    logic [2:0]        pmode_q, pmode_d;
    logic [MAXV_W-1:0] maxv_q, maxv_d;
    logic              fl_q, fl_d, rl_q, rl_d, sm_q, sm_d, nl_q, nl_d;
    always_comb begin
        pmode_d = pmode_q;
        maxv_d  = maxv_q;
        fl_d    = fl_q;
        rl_d    = rl_q;
        sm_d    = sm_q;
        nl_d    = nl_q;
        if (sel_i && wr_pmode_i && pmode_i <= 3'h5) pmode_d = pmode_i;
        if (sel_i && wr_maxv_i) maxv_d = (maxv_i > MAXV_LIMIT) ? MAXV_LIMIT : maxv_i;
        if (sel_i && wr_lmt_i) begin
            fl_d = fwd_lvl_i;
            rl_d = rev_lvl_i;
        end
        if (sel_i && wr_stop_i) sm_d = stop_mode_i;
        if (sel_i && wr_nh_i) nl_d = nh_lvl_i;
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pmode_q <= PMODE_RESET;
            maxv_q  <= MAXV_RESET;
            fl_q    <= LEVEL_RESET;
            rl_q    <= LEVEL_RESET;
            sm_q    <= STOP_RESET;
            nl_q    <= LEVEL_RESET;
        end else if (soft_rst_i) begin
            pmode_q <= PMODE_RESET;
            maxv_q  <= MAXV_RESET;
            fl_q    <= LEVEL_RESET;
            rl_q    <= LEVEL_RESET;
            sm_q    <= STOP_RESET;
            nl_q    <= LEVEL_RESET;
        end else begin
            pmode_q <= pmode_d;
            maxv_q  <= maxv_d;
            fl_q    <= fl_d;
            rl_q    <= rl_d;
            sm_q    <= sm_d;
            nl_q    <= nl_d;
        end
    end

    // ****************************************
    // Sensor synchronisers
    // ****************************************
    logic [2:0] s1_q, s2_q;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
        end else begin
            s1_q <= {near_origin_sensor_i, rev_lmt_i, fwd_lmt_i};
            s2_q <= s1_q;
        end
    end
    logic fwd_hit, rev_hit, near_hit;
    assign fwd_hit  = (s2_q[0] == fl_q);
    assign rev_hit  = (s2_q[1] == rl_q);
    assign near_hit = (s2_q[2] == nl_q);

    // ****************************************
    // Speed generator
    // ****************************************
    // Rate in PPS = speed * maxv / 8000; the accumulator adds speed*maxv
    // each clock and emits a step when it passes 8000*CLK_HZ.
    localparam logic [63:0] STEP_THR = 64'(SPEED_DIV) * 64'(CLK_HZ);
    run_state_t        st_q, st_d;
    logic [SPEED_W-1:0] sp_q, sp_d;
    logic [63:0]       acc_q, acc_d;
    logic [MAXV_W-1:0] scale;
    logic              step, lim_dir;
    assign scale   = scale_ext_i ? scale_maxv_i : maxv_q;
    assign lim_dir = dir_rev_i ? rev_hit : fwd_hit;
    always_comb begin
        st_d  = st_q;
        sp_d  = sp_q;
        acc_d = acc_q;
        step  = 1'b0;
        unique case (st_q)
            ST_IDLE: begin
                acc_d = 64'h0;
                if (run_i && !lim_dir) begin
                    st_d = ST_RUN;
                    sp_d = start_sp_i;
                end
            end
            ST_RUN: begin
                if (lim_dir && !sm_q) st_d = ST_IDLE;
                else if (lim_dir || !run_i) st_d = ST_DEC;
                else if (sp_q < target_sp_i) begin
                    sp_d = (target_sp_i - sp_q > accel_i) ? sp_q + accel_i : target_sp_i;
                end
            end
            ST_DEC: begin
                if (sp_q <= start_sp_i || sp_q <= accel_i) st_d = ST_IDLE;
                else sp_d = sp_q - accel_i;
            end
            default: st_d = ST_IDLE;
        endcase
        if (st_q != ST_IDLE) begin
            acc_d = acc_q + 64'(sp_q) * 64'(scale);
            if (acc_d >= STEP_THR) begin
                acc_d = acc_d - STEP_THR;
                step  = 1'b1;
            end
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q  <= ST_IDLE;
            sp_q  <= '0;
            acc_q <= 64'h0;
        end else if (soft_rst_i) begin
            st_q  <= ST_IDLE;
            sp_q  <= '0;
            acc_q <= 64'h0;
        end else begin
            st_q  <= st_d;
            sp_q  <= sp_d;
            acc_q <= acc_d;
        end
    end

    // ****************************************
    // Pulse encoder
    // ****************************************
    logic [2:0] pw_q, pw_d;
    logic       pa_d, dr_q, dr_d, pp_d, pm_d, fall;
    always_comb begin
        pw_d = pw_q;
        dr_d = dr_q;
        if (step) begin
            pw_d = 3'(PULSE_HI_CYC);
            dr_d = dir_rev_i;
        end else if (pw_q != 3'h0) pw_d = pw_q - 3'h1;
        pa_d = (pw_d != 3'h0);
        fall = (pmode_q == 3'h1) || (pmode_q == 3'h3) || (pmode_q == 3'h5);
        if (pmode_q <= 3'h1) begin
            pp_d = (pa_d && !dr_d) ^ fall;
            pm_d = (pa_d && dr_d) ^ fall;
        end else begin
            pp_d = pa_d ^ fall;
            pm_d = (pmode_q <= 3'h3) ? dr_d : !dr_d;
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pw_q <= 3'h0;
            dr_q <= 1'b0;
            pulse_out_plus_o  <= 1'b0;
            pulse_out_minus_o <= 1'b0;
            busy_o     <= 1'b0;
            fwd_hit_o  <= 1'b0;
            rev_hit_o  <= 1'b0;
            near_hit_o <= 1'b0;
        end else begin
            pw_q <= soft_rst_i ? 3'h0 : pw_d;
            dr_q <= soft_rst_i ? 1'b0 : dr_d;
            pulse_out_plus_o  <= soft_rst_i ? 1'b0 : pp_d;
            pulse_out_minus_o <= soft_rst_i ? 1'b0 : pm_d;
            busy_o     <= (st_q != ST_IDLE);
            fwd_hit_o  <= fwd_hit;
            rev_hit_o  <= rev_hit;
            near_hit_o <= near_hit;
        end
    end
    assign maxv_o = maxv_q;
endmodule : axis_channel

// [design/axis_cfg_pkg.sv]
// Shared constants for the four-axis pulse output configuration block
// Notes on behaviour
// - Axis mask: X=1, Y=2, Z=4, U=8; any mix, applied to all selected.
// - CW/CCW modes: forward on plus, reverse on minus; mode 0 rising, 1 falling.
// - Pulse/dir: plus steps, minus is direction; 2,4 rising; 3,5 falling; 2,3 low=fwd.
// - Speed resolution equals programmed maximum rate divided by 8000.
// - Maximum rate never above 4,000,000 PPS, giving 500 PPS resolution.
// - Same speed scale applies to start speed, acceleration and jerk.
// - Forward limit active level per axis: 0 low active, 1 high active.
// - Reverse limit active level per axis: 0 low active, 1 high active.
// - Asserted limit stops motion: mode 0 at once, mode 1 by deceleration.
// - Near-origin sensor active level per axis: 0 low, 1 high active.
// - Software reset command returns the module to reset state; the sensor synchronisers and busy/hit output registers are not cleared and keep sampling.
// - Interpolated motion uses the first axis maximum speed.
package axis_cfg_pkg;
    localparam int          NUM_AXES         = 4;
    localparam logic [3:0]  all_four_axes_mask = 4'hF;
    localparam int          MAXV_W           = 22;
    localparam logic [21:0] MAXV_LIMIT       = 22'h3D0900;  // 4,000,000 PPS
    localparam logic [21:0] SPEED_DIV        = 22'h001F40;  // 8000
    localparam logic [21:0] MAXV_RESET       = 22'h001F40;
    localparam logic [2:0]  PMODE_RESET      = 3'h0;
    localparam logic        LEVEL_RESET      = 1'b0;
    localparam logic        STOP_RESET       = 1'b0;
    localparam int          CLK_HZ           = 200000000;
    localparam int          ACC_W            = 28;
    localparam int          SPEED_W          = 13;
    localparam int          PULSE_HI_CYC     = 4;           // Pulse width in clocks
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DEC  = 2'b10
    } run_state_t;
endpackage : axis_cfg_pkg

// [design/axis_pulse_output_config.sv]
// Top of the four-axis pulse output configuration block
`timescale 1ns/10ps
module axis_pulse_output_config
    import axis_cfg_pkg::*;
(
    input  wire logic                clock_i,        // 200 MHz clock
    input  wire logic                rst_n_i,        // Async reset, active low
    input  wire logic                soft_rst_i,     // Software reset command pulse
    input  wire logic [3:0]          axis_sel_i,     // Axis mask X=1 Y=2 Z=4 U=8
    input  wire logic                wr_pmode_i,     // Write pulse mode pulse
    input  wire logic                wr_maxv_i,      // Write max speed pulse
    input  wire logic                wr_lmt_i,       // Write limit levels pulse
    input  wire logic                wr_stop_i,      // Write stop mode pulse
    input  wire logic                wr_nh_i,        // Write near-origin level pulse
    input  wire logic [2:0]          pmode_i,        // Pulse mode 0..5
    input  wire logic [MAXV_W-1:0]   maxv_i,         // Max speed in PPS
    input  wire logic                fwd_limit_level_i,  // Forward limit level
    input  wire logic                rev_limit_level_i,  // Reverse limit level
    input  wire logic                stop_mode_i,    // 0 immediate, 1 decelerate
    input  wire logic                near_origin_level_i, // Near-origin level
    input  wire logic                interp_i,       // Interpolated motion active
    input  wire logic [3:0]          run_i,          // Per-axis drive request
    input  wire logic [3:0]          dir_rev_i,      // Per-axis direction, 1 reverse
    input  wire logic [SPEED_W-1:0]  start_sp_i,     // Start speed, scaled
    input  wire logic [SPEED_W-1:0]  target_sp_i,    // Target speed, scaled
    input  wire logic [SPEED_W-1:0]  accel_i,        // Speed step per clock, scaled
    input  wire logic [3:0]          fwd_lmt_i,      // Forward limit pins
    input  wire logic [3:0]          rev_lmt_i,      // Reverse limit pins
    input  wire logic [3:0]          near_origin_sensor_i, // Near-origin pins
    output logic [3:0]               pulse_out_plus_o,  // Plus outputs
    output logic [3:0]               pulse_out_minus_o, // Minus outputs
    output logic [3:0]               busy_o,         // Axis driving
    output logic [3:0]               fwd_hit_o,      // Forward limit asserted
    output logic [3:0]               rev_hit_o,      // Reverse limit asserted
    output logic [3:0]               near_hit_o      // Near-origin asserted
);
    // ****************************************
    // Axis channels
    // ****************************************
    logic [MAXV_W-1:0] maxv_w [NUM_AXES];
    for (genvar g = 0; g < NUM_AXES; g++) begin : g_axis
        axis_channel u_ch (
            .clock_i              (clock_i),
            .rst_n_i              (rst_n_i),
            .soft_rst_i           (soft_rst_i),
            .sel_i                (axis_sel_i[g]),
            .wr_pmode_i           (wr_pmode_i),
            .wr_maxv_i            (wr_maxv_i),
            .wr_lmt_i             (wr_lmt_i),
            .wr_stop_i            (wr_stop_i),
            .wr_nh_i              (wr_nh_i),
            .pmode_i              (pmode_i),
            .maxv_i               (maxv_i),
            .fwd_lvl_i            (fwd_limit_level_i),
            .rev_lvl_i            (rev_limit_level_i),
            .stop_mode_i          (stop_mode_i),
            .nh_lvl_i             (near_origin_level_i),
            .scale_ext_i          (interp_i),
            .scale_maxv_i         (maxv_w[0]),
            .run_i                (run_i[g]),
            .dir_rev_i            (dir_rev_i[g]),
            .start_sp_i           (start_sp_i),
            .target_sp_i          (target_sp_i),
            .accel_i              (accel_i),
            .fwd_lmt_i            (fwd_lmt_i[g]),
            .rev_lmt_i            (rev_lmt_i[g]),
            .near_origin_sensor_i (near_origin_sensor_i[g]),
            .pulse_out_plus_o     (pulse_out_plus_o[g]),
            .pulse_out_minus_o    (pulse_out_minus_o[g]),
            .busy_o               (busy_o[g]),
            .fwd_hit_o            (fwd_hit_o[g]),
            .rev_hit_o            (rev_hit_o[g]),
            .near_hit_o           (near_hit_o[g]),
            .maxv_o               (maxv_w[g])
        );
    end
endmodule : axis_pulse_output_config

// [verif/axis_cfg_props.sv]
// Concurrent checks on the pulse output configuration block
`timescale 1ns/10ps
module axis_cfg_props
    import axis_cfg_pkg::*;
(
    input wire logic       clock_i,              // Clock
    input wire logic       rst_n_i,              // Reset
    input wire logic       soft_rst_i,           // Soft reset
    input wire logic [3:0] axis_sel_i,           // Axis mask
    input wire logic       wr_pmode_i,           // Mode write
    input wire logic       wr_lmt_i,             // Limit write
    input wire logic       wr_stop_i,            // Stop write
    input wire logic       wr_nh_i,              // Near write
    input wire logic [2:0] pmode_i,              // Mode
    input wire logic       fwd_limit_level_i,    // Fwd level
    input wire logic       rev_limit_level_i,    // Rev level
    input wire logic       stop_mode_i,          // Stop mode
    input wire logic       near_origin_level_i,  // Near level
    input wire logic [3:0] dir_rev_i,            // Direction
    input wire logic [3:0] fwd_lmt_i,            // Fwd pins
    input wire logic [3:0] rev_lmt_i,            // Rev pins
    input wire logic [3:0] near_origin_sensor_i, // Near pins
    input wire logic [3:0] pulse_out_plus_o,     // Plus
    input wire logic [3:0] pulse_out_minus_o,    // Minus
    input wire logic [3:0] busy_o,               // Busy
    input wire logic [3:0] fwd_hit_o,            // Fwd hit
    input wire logic [3:0] rev_hit_o,            // Rev hit
    input wire logic [3:0] near_hit_o            // Near hit
);
    logic [3:0] fl_q, rl_q, nl_q, sm_q;
    logic [2:0] pm_q;

    // Shadow copy of the per-axis settings
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {fl_q, rl_q, nl_q, sm_q, pm_q} <= '0;
        end else if (soft_rst_i) begin
            {fl_q, rl_q, nl_q, sm_q, pm_q} <= '0;
        end else begin
            for (int a = 0; a < 4; a++) begin
                if (axis_sel_i[a] && wr_lmt_i) begin
                    fl_q[a] <= fwd_limit_level_i;
                    rl_q[a] <= rev_limit_level_i;
                end
                if (axis_sel_i[a] && wr_nh_i) nl_q[a] <= near_origin_level_i;
                if (axis_sel_i[a] && wr_stop_i) sm_q[a] <= stop_mode_i;
            end
            if (axis_sel_i[0] && wr_pmode_i && pmode_i <= 3'h5) pm_q <= pmode_i;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_calm;
        (!soft_rst_i && !wr_lmt_i && !wr_nh_i && !wr_pmode_i && !wr_stop_i && $stable(dir_rev_i)
            && $stable(fwd_lmt_i) && $stable(rev_lmt_i) && $stable(near_origin_sensor_i)) [*8];
    endsequence
    sequence s_fwd_blocked;
        (!busy_o[0] && fwd_hit_o[0] && !dir_rev_i[0]) [*3];
    endsequence

    property p_fwd_hit; s_calm |-> fwd_hit_o == ~(fwd_lmt_i ^ fl_q); endproperty
    property p_rev_hit; s_calm |-> rev_hit_o == ~(rev_lmt_i ^ rl_q); endproperty
    property p_near_hit; s_calm |-> near_hit_o == ~(near_origin_sensor_i ^ nl_q); endproperty
    property p_cw_minus; s_calm ##0 (pm_q == 3'h0 && !dir_rev_i[0]) |-> !pulse_out_minus_o[0]; endproperty
    property p_cw_plus; s_calm ##0 (pm_q == 3'h0 && dir_rev_i[0]) |-> !pulse_out_plus_o[0]; endproperty
    property p_soft; soft_rst_i |-> ##[1:2] busy_o == 4'h0; endproperty
    property p_stop_now; busy_o[0] && fwd_hit_o[0] && !dir_rev_i[0] && !sm_q[0] |-> ##[1:2] !busy_o[0]; endproperty
    property p_no_start; s_fwd_blocked |=> !busy_o[0]; endproperty

    a_fwd_hit: assert property (p_fwd_hit) else $error("forward limit flag wrong");
    a_rev_hit: assert property (p_rev_hit) else $error("reverse limit flag wrong");
    a_near_hit: assert property (p_near_hit) else $error("near origin flag wrong");
    a_cw_minus: assert property (p_cw_minus) else $error("minus line moved on forward");
    a_cw_plus: assert property (p_cw_plus) else $error("plus line moved on reverse");
    a_soft: assert property (p_soft) else $error("motion kept after soft reset");
    a_stop_now: assert property (p_stop_now) else $error("no immediate stop on limit");
    a_no_start: assert property (p_no_start) else $error("started into asserted limit");
endmodule : axis_cfg_props

bind axis_pulse_output_config axis_cfg_props props_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .soft_rst_i(soft_rst_i), .axis_sel_i(axis_sel_i), .wr_pmode_i(wr_pmode_i), .wr_lmt_i(wr_lmt_i),
    .wr_stop_i(wr_stop_i), .wr_nh_i(wr_nh_i), .pmode_i(pmode_i), .fwd_limit_level_i(fwd_limit_level_i),
    .rev_limit_level_i(rev_limit_level_i), .stop_mode_i(stop_mode_i), .near_origin_level_i(near_origin_level_i),
    .dir_rev_i(dir_rev_i), .fwd_lmt_i(fwd_lmt_i), .rev_lmt_i(rev_lmt_i), .near_origin_sensor_i(near_origin_sensor_i),
    .pulse_out_plus_o(pulse_out_plus_o), .pulse_out_minus_o(pulse_out_minus_o), .busy_o(busy_o),
    .fwd_hit_o(fwd_hit_o), .rev_hit_o(rev_hit_o), .near_hit_o(near_hit_o));

// [verif/axis_drive_model.sv]
// Motor driver and sensor model: counts pulse edges, drives sensor pins
`timescale 1ns/10ps
module axis_drive_model (
    input  wire logic       clock_i,   // Clock
    input  wire logic [3:0] plus_i,    // Plus lines
    input  wire logic [3:0] minus_i,   // Minus lines
    output logic      [3:0] fwd_lmt_o, // Fwd pins
    output logic      [3:0] rev_lmt_o, // Rev pins
    output logic      [3:0] near_o     // Near pins
);
    int         rise_p [4] = '{default: 0};
    int         edge_m [4] = '{default: 0};
    logic [3:0] p_q        = 4'h0;
    logic [3:0] m_q        = 4'h0;

    initial {fwd_lmt_o, rev_lmt_o, near_o} = '0;

    always @(posedge clock_i) begin
        for (int a = 0; a < 4; a++) begin
            if (plus_i[a] && !p_q[a]) rise_p[a]++;
            if (minus_i[a] !== m_q[a]) edge_m[a]++;
        end
        p_q <= plus_i;
        m_q <= minus_i;
    end

    task automatic set_pins(input logic [3:0] f, input logic [3:0] r, input logic [3:0] n);
        fwd_lmt_o <= f;
        rev_lmt_o <= r;
        near_o    <= n;
    endtask : set_pins
endmodule : axis_drive_model

// [verif/tb_top.sv]
// Self-checking bench of the pulse output configuration block
`timescale 1ns/10ps
module tb_top
    import axis_cfg_pkg::*;
;
    logic               clock_i, rst_n_i, soft_rst_i, interp_i, fl, rl, sm, nl;
    logic [4:0]         wr_s;
    logic [3:0]         axis_sel_i, run_i, dir_rev_i, plus, minus, busy, fhit, rhit, nhit, fpin, rpin, npin;
    logic [2:0]         pmode_i;
    logic [MAXV_W-1:0]  maxv_i;
    logic [SPEED_W-1:0] start_sp_i, target_sp_i, accel_i;
    int                 failures = 0;
    int                 comparisons = 0;

    axis_pulse_output_config dut_u (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .soft_rst_i(soft_rst_i), .axis_sel_i(axis_sel_i),
        .wr_pmode_i(wr_s[0]), .wr_maxv_i(wr_s[1]), .wr_lmt_i(wr_s[2]), .wr_stop_i(wr_s[3]), .wr_nh_i(wr_s[4]),
        .pmode_i(pmode_i), .maxv_i(maxv_i), .fwd_limit_level_i(fl), .rev_limit_level_i(rl),
        .stop_mode_i(sm), .near_origin_level_i(nl), .interp_i(interp_i), .run_i(run_i),
        .dir_rev_i(dir_rev_i), .start_sp_i(start_sp_i), .target_sp_i(target_sp_i), .accel_i(accel_i),
        .fwd_lmt_i(fpin), .rev_lmt_i(rpin), .near_origin_sensor_i(npin), .pulse_out_plus_o(plus),
        .pulse_out_minus_o(minus), .busy_o(busy), .fwd_hit_o(fhit), .rev_hit_o(rhit), .near_hit_o(nhit));
    axis_drive_model model_u (.clock_i(clock_i), .plus_i(plus), .minus_i(minus),
        .fwd_lmt_o(fpin), .rev_lmt_o(rpin), .near_o(npin));

    always #2.5 clock_i = ~clock_i;

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One write: k selects strobe 0 mode, 1 max speed, 2 limits, 3 stop, 4 near
    task automatic wr(input int k, input logic [3:0] m, input logic [21:0] v);
        @(posedge clock_i);
        axis_sel_i <= m;
        wr_s <= 5'(1 << k);
        {pmode_i, maxv_i, fl, rl, sm, nl} <= {v[2:0], v, v[0], v[1], v[0], v[0]};
        @(posedge clock_i);
        wr_s <= 5'h00;
    endtask : wr

    task automatic spd(input logic [21:0] mx, input logic [21:0] my, input logic it, input int ax, input int n);
        int c;
        wr(1, 4'h1, mx);
        wr(1, 4'h2, my);
        interp_i <= it;
        run_i[ax] <= 1'b1;
        cyc(100);
        c = model_u.rise_p[ax];
        cyc(800);
        c = model_u.rise_p[ax] - c;
        chk("pulse_count", 32'(c >= n - 1 && c <= n + 1), 32'h1);
        run_i <= 4'h0;
        interp_i <= 1'b0;
        cyc(20);
    endtask : spd

    task automatic test_done;
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        #(5 * 60000);
        failures++;
        test_done();
    end

    initial begin
        int ef, pr, me, w;
        {clock_i, rst_n_i, soft_rst_i, interp_i, wr_s, axis_sel_i, run_i, dir_rev_i} = '0;
        {pmode_i, maxv_i, fl, rl, sm, nl} = '0;
        {start_sp_i, target_sp_i, accel_i} = {13'h1F40, 13'h1F40, 13'h0004};
        cyc(3);
        rst_n_i <= 1'b1;
        cyc(6);
        chk("hit_default", 32'({fhit, rhit, nhit}), 32'hFFF);
        model_u.set_pins(4'h5, 4'h3, 4'h6);
        for (int m = 1; m < 16; m++) begin
            wr(2, 4'hF, 22'h2);
            wr(2, 4'(m), 22'h1);
            wr(4, 4'hF, 22'h0);
            wr(4, 4'(m), 22'h1);
            cyc(6);
            chk("fwd_hit", 32'(fhit), 32'(4'(~(4'h5 ^ 4'(m)))));
            chk("rev_hit", 32'(rhit), 32'(4'(4'h3 ^ 4'(m))));
            chk("near_hit", 32'(nhit), 32'(4'(~(4'h6 ^ 4'(m)))));
        end
        soft_rst_i <= 1'b1;
        cyc(1);
        soft_rst_i <= 1'b0;
        cyc(6);
        chk("hit_after_soft", 32'({fhit, rhit, nhit}), 32'hAC9);
        model_u.set_pins(4'h0, 4'h0, 4'h0);
        wr(2, 4'hF, 22'h3);
        spd(22'h3D0900, 22'h001F40, 1'b0, 0, 16);
        spd(22'h1E8480, 22'h001F40, 1'b0, 0, 8);
        spd(22'h3FFFFF, 22'h001F40, 1'b0, 0, 16);
        spd(22'h3D0900, 22'h1E8480, 1'b1, 1, 16);
        for (int k = 0; k < 7; k++) begin
            ef = (k > 5) ? 5 : k;
            wr(0, 4'h1, (k > 5) ? 22'h7 : 22'(k));
            for (int d = 0; d < 2; d++) begin
                dir_rev_i <= 4'(d);
                cyc(10);
                pr = model_u.rise_p[0];
                me = model_u.edge_m[0];
                run_i <= 4'h1;
                cyc(300);
                if (ef >= 2) chk("dir_line", 32'(minus[0]), 32'((ef < 4) ? d : 1 - d));
                chk("plus_steps", 32'(model_u.rise_p[0] > pr), 32'(ef >= 2 || d == 0));
                if (ef < 2) chk("minus_steps", 32'(model_u.edge_m[0] > me), 32'(d));
                run_i <= 4'h0;
                cyc(20);
                chk("plus_idle", 32'(plus[0]), 32'(ef % 2));
            end
        end
        wr(0, 4'h1, 22'h0);
        dir_rev_i <= 4'h0;
        start_sp_i <= 13'h0064;
        for (int s = 0; s < 2; s++) begin
            wr(3, 4'h1, 22'(s));
            run_i <= 4'h1;
            cyc(2500);
            model_u.set_pins(4'h1, 4'h0, 4'h0);
            cyc(12);
            chk("busy_after_hit", 32'(busy[0]), 32'(s));
            w = 0;
            while (busy[0] && w < 4000) begin
                cyc(1);
                w++;
            end
            cyc(20);
            chk("busy_blocked", 32'(busy[0]), 32'h0);
            dir_rev_i <= 4'h1;
            cyc(10);
            chk("busy_reverse", 32'(busy[0]), 32'h1);
            run_i <= 4'h0;
            cyc(20);
            dir_rev_i <= 4'h0;
            model_u.set_pins(4'h0, 4'h0, 4'h0);
            cyc(10);
        end
        run_i <= 4'h1;
        cyc(50);
        chk("busy_before_soft", 32'(busy[0]), 32'h1);
        soft_rst_i <= 1'b1;
        run_i <= 4'h0;
        cyc(1);
        soft_rst_i <= 1'b0;
        cyc(6);
        chk("busy_after_soft", 32'(busy), 32'h0);
        chk("plus_after_soft", 32'(plus), 32'h0);
        test_done();
    end
endmodule : tb_top
